// file: mcc_calib.sv
// Calibration correction stage: trim registers and correction datapath
`timescale 1ns/1ps

// Overview of operation
// - Control 2 bits 8 and 9 extend phase trims to 0.01 degree.
// - Reactive phase trim is a signed 16-bit two's complement value.
// - Phase trim corrects the 90 degree voltage shifter error in reactive.
// - Corrected reactive equals reactive minus phase trim times active.
// - Active offset A is added to channel A active power.
// - Active offset B is added to channel B active power.
// - Reactive offset A is added to channel A reactive power.
// - Reactive offset B is added to channel B reactive power.
// - RMS offset A corrects the channel A current RMS result.
// - RMS offset B corrects the channel B current RMS result.
// - All offset trims are signed 16-bit two's complement values.
// - Gain factor is the signed gain trim divided by two to fifteen.
// - Adjusted B current is current plus current times gain factor.
// - Phase, offset and gain trims clear to zero on reset.
module mcc_calib (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [mcc_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [mcc_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [mcc_pkg::DATA_W-1:0] reg_rdata,
  input wire logic sample_valid,
  input wire logic signed [mcc_pkg::PWR_W-1:0] active_a_in,
  input wire logic signed [mcc_pkg::PWR_W-1:0] active_b_in,
  input wire logic signed [mcc_pkg::PWR_W-1:0] reactive_a_in,
  input wire logic signed [mcc_pkg::PWR_W-1:0] reactive_b_in,
  input wire logic signed [mcc_pkg::RMS_W-1:0] rms_a_in,
  input wire logic signed [mcc_pkg::RMS_W-1:0] rms_b_in,
  input wire logic signed [mcc_pkg::RMS_W-1:0] current_b_in,
  output logic result_valid,
  output logic signed [mcc_pkg::PWR_W-1:0] active_a_out,
  output logic signed [mcc_pkg::PWR_W-1:0] active_b_out,
  output logic signed [mcc_pkg::PWR_W-1:0] reactive_a_out,
  output logic signed [mcc_pkg::PWR_W-1:0] reactive_b_out,
  output logic signed [mcc_pkg::RMS_W-1:0] rms_a_out,
  output logic signed [mcc_pkg::RMS_W-1:0] rms_b_out,
  output logic signed [mcc_pkg::RMS_W-1:0] current_b_out,
  output logic phase_a_fine,
  output logic phase_b_fine
);

  // ==========================================================
  // Trim registers
  logic signed [mcc_pkg::DATA_W-1:0] reactive_phase_trim;
  logic signed [mcc_pkg::DATA_W-1:0] active_offset_chan_a;
  logic signed [mcc_pkg::DATA_W-1:0] active_offset_chan_b;
  logic signed [mcc_pkg::DATA_W-1:0] reactive_offset_chan_a;
  logic signed [mcc_pkg::DATA_W-1:0] reactive_offset_chan_b;
  logic signed [mcc_pkg::DATA_W-1:0] rms_offset_chan_a;
  logic signed [mcc_pkg::DATA_W-1:0] rms_offset_chan_b;
  logic signed [mcc_pkg::DATA_W-1:0] chan_b_current_gain;
  logic [mcc_pkg::DATA_W-1:0] metering_control_2;
  logic [mcc_pkg::DATA_W-1:0] next_rdata;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      reactive_phase_trim <= mcc_pkg::TRIM_RESET;
      active_offset_chan_a <= mcc_pkg::TRIM_RESET;
      active_offset_chan_b <= mcc_pkg::TRIM_RESET;
      reactive_offset_chan_a <= mcc_pkg::TRIM_RESET;
      reactive_offset_chan_b <= mcc_pkg::TRIM_RESET;
      rms_offset_chan_a <= mcc_pkg::TRIM_RESET;
      rms_offset_chan_b <= mcc_pkg::TRIM_RESET;
      chan_b_current_gain <= mcc_pkg::TRIM_RESET;
      metering_control_2 <= mcc_pkg::CTRL2_RESET;
    end else if (reg_wr) begin
      unique case (reg_addr)
        mcc_pkg::ADDR_REACTIVE_PHASE_TRIM: begin
          reactive_phase_trim <= reg_wdata;
        end
        mcc_pkg::ADDR_ACTIVE_OFFSET_A: begin
          active_offset_chan_a <= reg_wdata;
        end
        mcc_pkg::ADDR_ACTIVE_OFFSET_B: begin
          active_offset_chan_b <= reg_wdata;
        end
        mcc_pkg::ADDR_REACTIVE_OFFSET_A: begin
          reactive_offset_chan_a <= reg_wdata;
        end
        mcc_pkg::ADDR_REACTIVE_OFFSET_B: begin
          reactive_offset_chan_b <= reg_wdata;
        end
        mcc_pkg::ADDR_RMS_OFFSET_A: begin
          rms_offset_chan_a <= reg_wdata;
        end
        mcc_pkg::ADDR_RMS_OFFSET_B: begin
          rms_offset_chan_b <= reg_wdata;
        end
        mcc_pkg::ADDR_CHAN_B_GAIN: begin
          chan_b_current_gain <= reg_wdata;
        end
        mcc_pkg::ADDR_METERING_CONTROL_2: begin
          // Reserved bits must stay zero, so they are masked off
          metering_control_2 <= reg_wdata & mcc_pkg::CTRL2_WMASK;
        end
        default: begin
        end
      endcase
    end
  end

  // ==========================================================
  // Read port
  always_comb begin
    unique case (reg_addr)
      mcc_pkg::ADDR_REACTIVE_PHASE_TRIM: next_rdata = reactive_phase_trim;
      mcc_pkg::ADDR_ACTIVE_OFFSET_A: next_rdata = active_offset_chan_a;
      mcc_pkg::ADDR_ACTIVE_OFFSET_B: next_rdata = active_offset_chan_b;
      mcc_pkg::ADDR_REACTIVE_OFFSET_A: next_rdata = reactive_offset_chan_a;
      mcc_pkg::ADDR_REACTIVE_OFFSET_B: next_rdata = reactive_offset_chan_b;
      mcc_pkg::ADDR_RMS_OFFSET_A: next_rdata = rms_offset_chan_a;
      mcc_pkg::ADDR_RMS_OFFSET_B: next_rdata = rms_offset_chan_b;
      mcc_pkg::ADDR_CHAN_B_GAIN: next_rdata = chan_b_current_gain;
      mcc_pkg::ADDR_METERING_CONTROL_2: next_rdata = metering_control_2;
      default: next_rdata = mcc_pkg::READ_UNMAPPED;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      reg_rdata <= mcc_pkg::READ_UNMAPPED;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= mcc_pkg::READ_UNMAPPED;
    end
  end

  // ==========================================================
  // Fine phase step bits, handed to the voltage delay line
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      phase_a_fine <= 1'b0;
      phase_b_fine <= 1'b0;
    end else begin
      phase_a_fine <= metering_control_2[mcc_pkg::CTRL2_PHASE_A_LSB];
      phase_b_fine <= metering_control_2[mcc_pkg::CTRL2_PHASE_B_LSB];
    end
  end

  // ==========================================================
  // Correction datapath
  // Products keep full width; results truncate after the shift by 2^15
  localparam int PROD_W = mcc_pkg::PWR_W + mcc_pkg::DATA_W;
  localparam int IPROD_W = mcc_pkg::RMS_W + mcc_pkg::DATA_W;
  logic signed [PROD_W-1:0] phase_prod_a;
  logic signed [PROD_W-1:0] phase_prod_b;
  logic signed [IPROD_W-1:0] gain_prod;
  logic signed [mcc_pkg::PWR_W-1:0] active_a_corr;
  logic signed [mcc_pkg::PWR_W-1:0] active_b_corr;
  logic signed [mcc_pkg::PWR_W-1:0] reactive_a_corr;
  logic signed [mcc_pkg::PWR_W-1:0] reactive_b_corr;
  logic signed [mcc_pkg::PWR_W-1:0] phase_term_a;
  logic signed [mcc_pkg::PWR_W-1:0] phase_term_b;
  logic signed [mcc_pkg::RMS_W-1:0] gain_term;

  // Offsets enter the active power first, so the phase term sees it
  assign active_a_corr = active_a_in + mcc_pkg::PWR_W'(active_offset_chan_a);
  assign active_b_corr = active_b_in + mcc_pkg::PWR_W'(active_offset_chan_b);
  assign phase_prod_a = active_a_corr * reactive_phase_trim;
  assign phase_prod_b = active_b_corr * reactive_phase_trim;
  assign phase_term_a = phase_prod_a[mcc_pkg::FRAC_W +: mcc_pkg::PWR_W];
  assign phase_term_b = phase_prod_b[mcc_pkg::FRAC_W +: mcc_pkg::PWR_W];
  assign reactive_a_corr = reactive_a_in - phase_term_a;
  assign reactive_b_corr = reactive_b_in - phase_term_b;
  assign gain_prod = current_b_in * chan_b_current_gain;
  assign gain_term = gain_prod[mcc_pkg::FRAC_W +: mcc_pkg::RMS_W];

  // Results are registered once; the store stage sees offset-corrected data
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      result_valid <= 1'b0;
      active_a_out <= '0;
      active_b_out <= '0;
      reactive_a_out <= '0;
      reactive_b_out <= '0;
      rms_a_out <= '0;
      rms_b_out <= '0;
      current_b_out <= '0;
    end else begin
      result_valid <= sample_valid;
      if (sample_valid) begin
        active_a_out <= active_a_corr;
        active_b_out <= active_b_corr;
        reactive_a_out <= reactive_a_corr
          + mcc_pkg::PWR_W'(reactive_offset_chan_a);
        reactive_b_out <= reactive_b_corr
          + mcc_pkg::PWR_W'(reactive_offset_chan_b);
        rms_a_out <= rms_a_in + mcc_pkg::RMS_W'(rms_offset_chan_a);
        rms_b_out <= rms_b_in + mcc_pkg::RMS_W'(rms_offset_chan_b);
        current_b_out <= current_b_in + gain_term;
      end
    end
  end

endmodule : mcc_calib

// file: mcc_pkg.sv
// Package of register map, widths and constants for the calibration stage
package mcc_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int PWR_W = 32;
  localparam int RMS_W = 24;
  localparam int FRAC_W = 15;
  localparam logic [ADDR_W-1:0] ADDR_REACTIVE_PHASE_TRIM = 8'h09;
  localparam logic [ADDR_W-1:0] ADDR_ACTIVE_OFFSET_A = 8'h0a;
  localparam logic [ADDR_W-1:0] ADDR_ACTIVE_OFFSET_B = 8'h0b;
  localparam logic [ADDR_W-1:0] ADDR_REACTIVE_OFFSET_A = 8'h0c;
  localparam logic [ADDR_W-1:0] ADDR_REACTIVE_OFFSET_B = 8'h0d;
  localparam logic [ADDR_W-1:0] ADDR_RMS_OFFSET_A = 8'h0e;
  localparam logic [ADDR_W-1:0] ADDR_RMS_OFFSET_B = 8'h0f;
  localparam logic [ADDR_W-1:0] ADDR_CHAN_B_GAIN = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_METERING_CONTROL_2 = 8'h17;
  localparam logic [DATA_W-1:0] TRIM_RESET = 16'h0000;
  localparam logic [DATA_W-1:0] CTRL2_RESET = 16'h0000;
  localparam logic [DATA_W-1:0] CTRL2_WMASK = 16'h33f8;
  localparam int CTRL2_PHASE_A_LSB = 8;
  localparam int CTRL2_PHASE_B_LSB = 9;
  localparam logic [DATA_W-1:0] READ_UNMAPPED = 16'h0000;
endpackage : mcc_pkg

// file: mcc_calib_checker.sv
// Checker of bus and datapath timing for the calibration stage
`timescale 1ns/1ps
// ==========
// Port watcher
module mcc_calib_checker (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [mcc_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [mcc_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [mcc_pkg::DATA_W-1:0] reg_rdata,
  input wire logic sample_valid,
  input wire logic signed [mcc_pkg::RMS_W-1:0] current_b_in,
  input wire logic result_valid,
  input wire logic signed [mcc_pkg::PWR_W-1:0] active_a_out,
  input wire logic signed [mcc_pkg::RMS_W-1:0] current_b_out
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  property p_valid; result_valid == $past(sample_valid); endproperty
  a_valid: assert property (p_valid) else $error("valid late");
  property p_hold; !sample_valid |=> $stable(active_a_out); endproperty
  a_hold: assert property (p_hold) else $error("active moved");
  property p_cb_hold; !sample_valid |=> $stable(current_b_out); endproperty
  a_cb_hold: assert property (p_cb_hold) else $error("cur moved");
  property p_cb0; sample_valid && current_b_in == 0 |=> current_b_out == 0;
  endproperty
  a_cb0: assert property (p_cb0) else $error("cur not zero");
  property p_rst; $fell(srst) |-> !result_valid && current_b_out == 0;
  endproperty
  a_rst: assert property (p_rst) else $error("not clear");
  property p_rb_ph;
    (reg_wr && reg_addr == mcc_pkg::ADDR_REACTIVE_PHASE_TRIM)
    ##1 (reg_rd && reg_addr == mcc_pkg::ADDR_REACTIVE_PHASE_TRIM)
    |=> reg_rdata == $past(reg_wdata, 2);
  endproperty
  a_rb_ph: assert property (p_rb_ph) else $error("phase rb");
  property p_rb_rms;
    (reg_wr && reg_addr == mcc_pkg::ADDR_RMS_OFFSET_A)
    ##1 (reg_rd && reg_addr == mcc_pkg::ADDR_RMS_OFFSET_A)
    |=> reg_rdata == $past(reg_wdata, 2);
  endproperty
  a_rb_rms: assert property (p_rb_rms) else $error("rms rb");
  property p_rb_g;
    (reg_wr && reg_addr == mcc_pkg::ADDR_CHAN_B_GAIN)
    ##1 (reg_rd && reg_addr == mcc_pkg::ADDR_CHAN_B_GAIN)
    |=> reg_rdata == $past(reg_wdata, 2);
  endproperty
  a_rb_g: assert property (p_rb_g) else $error("gain rb");
  c_rb: cover property (reg_wr ##1 reg_rd);
  c_smp: cover property (sample_valid ##1 result_valid);
  c_neg: cover property (sample_valid && current_b_in < 0);
endmodule : mcc_calib_checker
bind mcc_calib mcc_calib_checker u_chk (.*);

// file: mcc_calib_tb.sv
// Testbench of the calibration stage
`timescale 1ns/1ps
// ==========
// Stimulus and checks
module mcc_calib_tb;
  logic sys_clk = 1'b0, srst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic sample_valid = 1'b0, result_valid, phase_a_fine, phase_b_fine;
  logic [mcc_pkg::ADDR_W-1:0] reg_addr = '0;
  logic [mcc_pkg::DATA_W-1:0] reg_wdata = '0, reg_rdata;
  logic [mcc_pkg::DATA_W-1:0] tr [8] = '{default: '0};
  logic signed [mcc_pkg::PWR_W-1:0] active_a_in = '0, active_b_in = '0;
  logic signed [mcc_pkg::PWR_W-1:0] reactive_a_in = '0, reactive_b_in = '0;
  logic signed [mcc_pkg::PWR_W-1:0] active_a_out, active_b_out;
  logic signed [mcc_pkg::PWR_W-1:0] reactive_a_out, reactive_b_out;
  logic signed [mcc_pkg::RMS_W-1:0] rms_a_in = '0, rms_b_in = '0;
  logic signed [mcc_pkg::RMS_W-1:0] current_b_in = '0;
  logic signed [mcc_pkg::RMS_W-1:0] rms_a_out, rms_b_out, current_b_out;
  localparam logic [15:0] TV [8] = '{16'h4000, 16'h8000, 16'h7fff,
    16'hfff0, 16'h0010, 16'h8001, 16'h0003, 16'hc000};
  int miscompares = 0, comparisons = 0, cyc = 0;
  mcc_calib DUT (.*);
  task automatic chk(string n, logic [31:0] g, logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wr(logic [7:0] a, logic [15:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    if (a >= 8'h09 && a <= 8'h10) tr[a-8'h09] = d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr
  // Raises at once, so a read lands right behind a write
  task automatic rd(logic [7:0] a, logic [15:0] e);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 chk("rdata", reg_rdata, e);
    // Ends on an edge, so the next strobe is driven there too
    @(posedge sys_clk);
  endtask : rd
  function automatic longint o(int k);
    return $signed(tr[k]);
  endfunction : o
  // Channel B power and RMS inputs get the negated stimulus; current_b_in gets it unnegated
  task automatic smp(longint p, longint q, longint i);
    @(posedge sys_clk);
    sample_valid <= 1'b1;
    active_a_in <= 32'(p);
    active_b_in <= 32'(-p);
    reactive_a_in <= 32'(q);
    reactive_b_in <= 32'(-q);
    rms_a_in <= 24'(i);
    rms_b_in <= 24'(-i);
    current_b_in <= 24'(i);
    @(posedge sys_clk);
    sample_valid <= 1'b0;
    #1 chk("valid", result_valid, 1);
    chk("act_a", active_a_out, 32'(p + o(1)));
    chk("act_b", active_b_out, 32'(o(2) - p));
    chk("rea_a", reactive_a_out,
      32'(q - ((p + o(1)) * o(0) >>> 15) + o(3)));
    chk("rea_b", reactive_b_out,
      32'(o(4) - q - ((o(2) - p) * o(0) >>> 15)));
    chk("rms_a", rms_a_out, 24'(i + o(5)));
    chk("rms_b", rms_b_out, 24'(o(6) - i));
    chk("cur_b", current_b_out, 24'(i + (i * o(7) >>> 15)));
  endtask : smp
  task automatic report_and_stop();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : report_and_stop
  initial begin
    forever #2 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 2000) begin
      miscompares++;
      report_and_stop();
    end
  end
  initial begin
    repeat (10) @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
    foreach (tr[k]) rd(8'h09 + 8'(k), 16'h0000);
    rd(8'h17, 16'h0000);
    foreach (TV[k]) begin
      wr(8'h09 + 8'(k), TV[k]);
      rd(8'h09 + 8'(k), TV[k]);
    end
    wr(8'h20, 16'hffff);
    rd(8'h20, 16'h0000);
    wr(8'h17, 16'hffff);
    rd(8'h17, 16'h33f8);
    chk("fine_a", phase_a_fine, 1);
    wr(8'h17, 16'h0200);
    rd(8'h17, 16'h0200);
    chk("fine_a", phase_a_fine, 0);
    chk("fine_b", phase_b_fine, 1);
    smp(1000, 5000, 1000);
    smp(-70000, -3, -3);
    wr(8'h10, 16'h4000);
    smp(-3, 12, -3);
    wr(8'h10, 16'h8000);
    wr(8'h09, 16'h0000);
    smp(123456, -777, 4095);
    smp(5, 5, 0);
    report_and_stop();
  end
endmodule : mcc_calib_tb
